/* File: logic/ltsr_reporter.v */
// Function
// (RULE_01) 6-bit state code; 0/1 Detect Quiet, 2/3 Detect Active.
// (RULE_02) Polling Active 4, Configuration 5, compliance substates 6 to A.
// (RULE_03) Config linkwidth start B/C, accept D/E, lane wait F, accept 10.
// (RULE_04) Config Complete 11..14 by width x1..x8; Config Idle 15.
// (RULE_05) L0 16, L1 entry 17..19, idle 1A, exit 1B; 19 also L2/L3.
// (RULE_06) Recovery 1C..20, Hot Reset 21, Disabled entry 22..24, idle 25.
// (RULE_07) Root port configuration substates 26 through 2C.
// (RULE_08) Timeout to detect reported as 2D.
// (RULE_09) Loopback entry 2E/2F, active 30, exit 31/32, master entry 33.
// (RULE_10) 2-bit receive power state; 00 means not in L0s.
// (RULE_11) Code never above 33; outputs change only on clock edges (reset_n clears them asynchronously instead).
`timescale 1ns/1ps
`default_nettype none
`include "ltsr_consts.vh"

module ltsr_reporter (
    input  wire       clock,
    input  wire       reset_n,
    input  wire [3:0] state_group,
    input  wire [2:0] state_sub,
    input  wire       root_port_mode,
    input  wire [1:0] neg_width,
    input  wire [1:0] rx_power_state,
    output reg  [5:0] link_training_state_code,
    output reg  [1:0] rx_power_state_code
);

    // ----------------------------------------
    // Encoder
    // ----------------------------------------
    // Out-of-range substates clamp to the last legal code of their group
    function [5:0] ltsr_clamp;
        input [5:0] base;
        input [2:0] sub;
        input [2:0] last;
        begin
            if (sub > last) begin
                ltsr_clamp = base + {3'h0, last};
            end else begin
                ltsr_clamp = base + {3'h0, sub};
            end
        end
    endfunction

    // Detect: only the even code of each pair is ever produced
    function [5:0] ltsr_detect_code;
        input [2:0] sub;
        begin
            if (sub[0]) begin
                ltsr_detect_code = `LTSR_DETECT_ACTIVE;
            end else begin
                ltsr_detect_code = `LTSR_DETECT_QUIET;
            end
        end
    endfunction

    function [5:0] ltsr_poll_code;
        input [2:0] sub;
        begin
            case (sub)
                3'h0: begin
                    ltsr_poll_code = `LTSR_POLL_ACTIVE; // [RULE_02]
                end
                3'h1: begin
                    ltsr_poll_code = `LTSR_POLL_CONFIG; // [RULE_02]
                end
                default: begin
                    ltsr_poll_code = ltsr_clamp(`LTSR_POLL_COMPL_FIRST, sub - 3'h2, 3'h4);
                end
            endcase
        end
    endfunction

    function [5:0] ltsr_cfg_code;
        input [2:0] sub;
        input       rp;
        begin
            if (rp) begin
                ltsr_cfg_code = ltsr_clamp(`LTSR_RP_CFG_FIRST, sub, 3'h6); // [RULE_07]
            end else if (sub == 3'h6) begin
                ltsr_cfg_code = `LTSR_CFG_IDLE; // [RULE_04]
            end else begin
                // Substate 7 has no meaning here, parks on lane accept
                ltsr_cfg_code = ltsr_clamp(`LTSR_CFG_LW_START0, sub, 3'h5); // [RULE_03]
            end
        end
    endfunction

    function [5:0] ltsr_width_code;
        input [1:0] width;
        begin
            case (width)
                `LTSR_WIDTH_X1: begin
                    ltsr_width_code = `LTSR_CFG_COMPLETE_X1; // [RULE_04]
                end
                `LTSR_WIDTH_X2: begin
                    ltsr_width_code = `LTSR_CFG_COMPLETE_X2; // [RULE_04]
                end
                `LTSR_WIDTH_X4: begin
                    ltsr_width_code = `LTSR_CFG_COMPLETE_X4; // [RULE_04]
                end
                default: begin
                    ltsr_width_code = `LTSR_CFG_COMPLETE_X8; // [RULE_04]
                end
            endcase
        end
    endfunction

    function [5:0] ltsr_l1_code;
        input [2:0] sub;
        begin
            case (sub)
                3'h0: begin
                    ltsr_l1_code = `LTSR_L1_ENTRY0;
                end
                3'h1: begin
                    ltsr_l1_code = `LTSR_L1_ENTRY1;
                end
                3'h2: begin
                    // Shared with the L2/L3 Ready pseudo state
                    ltsr_l1_code = `LTSR_L1_ENTRY2;
                end
                3'h3: begin
                    ltsr_l1_code = `LTSR_L1_IDLE;
                end
                default: begin
                    ltsr_l1_code = `LTSR_L1_EXIT;
                end
            endcase
        end
    endfunction

    function [1:0] ltsr_rx_code;
        input [1:0] state;
        begin
            case (state)
                `LTSR_RX_L0S_ENTRY: begin
                    ltsr_rx_code = `LTSR_RX_L0S_ENTRY;
                end
                `LTSR_RX_L0S_IDLE: begin
                    ltsr_rx_code = `LTSR_RX_L0S_IDLE;
                end
                `LTSR_RX_L0S_FTS: begin
                    ltsr_rx_code = `LTSR_RX_L0S_FTS;
                end
                default: begin
                    ltsr_rx_code = `LTSR_RX_NOT_L0S; // [RULE_10]
                end
            endcase
        end
    endfunction

    reg [5:0] code_next;
    reg [1:0] rx_next;

    always @* begin
        rx_next = ltsr_rx_code(rx_power_state); // [RULE_10]
    end

    always @* begin
        code_next = `LTSR_DETECT_QUIET;
        case (state_group)
            `LTSR_GRP_DETECT: begin
                code_next = ltsr_detect_code(state_sub); // [RULE_01]
            end
            `LTSR_GRP_POLLING: begin
                code_next = ltsr_poll_code(state_sub); // [RULE_02]
            end
            `LTSR_GRP_CONFIG: begin
                code_next = ltsr_cfg_code(state_sub, root_port_mode); // [RULE_03]
            end
            `LTSR_GRP_CFG_COMPLETE: begin
                code_next = ltsr_width_code(neg_width); // [RULE_04]
            end
            `LTSR_GRP_L0: begin
                code_next = `LTSR_L0; // [RULE_05]
            end
            `LTSR_GRP_L1: begin
                code_next = ltsr_l1_code(state_sub); // [RULE_05]
            end
            `LTSR_GRP_RECOVERY: begin
                code_next = ltsr_clamp(`LTSR_RECOVERY_FIRST, state_sub, 3'h4); // [RULE_06]
            end
            `LTSR_GRP_HOT_RESET: begin
                code_next = `LTSR_HOT_RESET; // [RULE_06]
            end
            `LTSR_GRP_DISABLED: begin
                code_next = ltsr_clamp(`LTSR_DISABLED_ENTRY0, state_sub, 3'h3); // [RULE_06]
            end
            `LTSR_GRP_TIMEOUT: begin
                code_next = `LTSR_TIMEOUT_TO_DETECT; // [RULE_08]
            end
            `LTSR_GRP_LOOPBACK: begin
                code_next = ltsr_clamp(`LTSR_LOOPBACK_ENTRY0, state_sub, 3'h5); // [RULE_09]
            end
            default: begin
                // Unknown group falls back to Detect Quiet, never above the top code
                code_next = `LTSR_DETECT_QUIET; // [RULE_11]
            end
        endcase
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Registered so user logic never sees encoder glitches
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            link_training_state_code <= `LTSR_DETECT_QUIET;
            rx_power_state_code      <= `LTSR_RX_NOT_L0S;
        end else begin
            link_training_state_code <= code_next; // [RULE_11]
            rx_power_state_code      <= rx_next; // [RULE_10]
        end
    end

endmodule

`default_nettype wire

/* File: include/ltsr_consts.vh */
`ifndef LTSR_CONSTS_VH
`define LTSR_CONSTS_VH

// ----------------------------------------
// Training state codes
// ----------------------------------------
`define LTSR_DETECT_QUIET        6'h00
`define LTSR_DETECT_ACTIVE       6'h02
`define LTSR_POLL_ACTIVE         6'h04
`define LTSR_POLL_CONFIG         6'h05
`define LTSR_POLL_COMPL_FIRST    6'h06
`define LTSR_CFG_LW_START0       6'h0B
`define LTSR_CFG_LW_START1       6'h0C
`define LTSR_CFG_LW_ACCEPT0      6'h0D
`define LTSR_CFG_LW_ACCEPT1      6'h0E
`define LTSR_CFG_LN_WAIT         6'h0F
`define LTSR_CFG_LN_ACCEPT       6'h10
`define LTSR_CFG_COMPLETE_X1     6'h11
`define LTSR_CFG_COMPLETE_X2     6'h12
`define LTSR_CFG_COMPLETE_X4     6'h13
`define LTSR_CFG_COMPLETE_X8     6'h14
`define LTSR_CFG_IDLE            6'h15
`define LTSR_L0                  6'h16
`define LTSR_L1_ENTRY0           6'h17
`define LTSR_L1_ENTRY1           6'h18
`define LTSR_L1_ENTRY2           6'h19
`define LTSR_L1_IDLE             6'h1A
`define LTSR_L1_EXIT             6'h1B
`define LTSR_RECOVERY_FIRST      6'h1C
`define LTSR_HOT_RESET           6'h21
`define LTSR_DISABLED_ENTRY0     6'h22
`define LTSR_DISABLED_IDLE       6'h25
`define LTSR_RP_CFG_FIRST        6'h26
`define LTSR_TIMEOUT_TO_DETECT   6'h2D
`define LTSR_LOOPBACK_ENTRY0     6'h2E
`define LTSR_LOOPBACK_ACTIVE     6'h30
`define LTSR_LOOPBACK_EXIT0      6'h31
`define LTSR_LOOPBACK_MASTER     6'h33
`define LTSR_CODE_MAX            6'h33

// ----------------------------------------
// State groups and substates
// ----------------------------------------
`define LTSR_GRP_DETECT          4'h0
`define LTSR_GRP_POLLING         4'h1
`define LTSR_GRP_CONFIG          4'h2
`define LTSR_GRP_CFG_COMPLETE    4'h3
`define LTSR_GRP_L0              4'h4
`define LTSR_GRP_L1              4'h5
`define LTSR_GRP_RECOVERY        4'h6
`define LTSR_GRP_HOT_RESET       4'h7
`define LTSR_GRP_DISABLED        4'h8
`define LTSR_GRP_TIMEOUT         4'h9
`define LTSR_GRP_LOOPBACK        4'hA

`define LTSR_RX_NOT_L0S          2'h0
`define LTSR_RX_L0S_ENTRY        2'h1
`define LTSR_RX_L0S_IDLE         2'h2
`define LTSR_RX_L0S_FTS          2'h3
`define LTSR_WIDTH_X1            2'h0
`define LTSR_WIDTH_X2            2'h1
`define LTSR_WIDTH_X4            2'h2

`endif

/* File: bench/ltsr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ltsr_checker (input wire clock, reset_n, input wire [3:0] state_group,
    input wire [2:0] state_sub, input wire root_port_mode, input wire [1:0] neg_width,
    input wire [1:0] rx_power_state, input wire [5:0] link_training_state_code,
    input wire [1:0] rx_power_state_code);
    wire [5:0] c = link_training_state_code;
    wire [3:0] g = state_group;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_code_max: assert property (c <= 6'h33) else $error("code high");
    a_detect_code: assert property (g == 0 |=> c <= 6'h03) else $error("detect");
    a_width_code: assert property (g == 3 |=> c == 6'h11 + $past(neg_width))
        else $error("width");
    a_rp_code: assert property (g == 2 && root_port_mode |=> c - 6'h26 < 6'h07)
        else $error("root port");
    a_hot_code: assert property (g == 7 |=> c == 6'h21) else $error("hot");
    a_timeout_code: assert property (g == 9 |=> c == 6'h2D) else $error("timeout");
    a_loop_code: assert property (g == 10 |=> c >= 6'h2E) else $error("loop");
    a_rx_pass: assert property (1 |=> rx_power_state_code == $past(rx_power_state))
        else $error("rx");
    a_poll_code: assert property (g == 1 && state_sub == 0 |=> c == 6'h04)
        else $error("poll");
    a_cfg_code: assert property (g == 2 && !root_port_mode && state_sub == 0 |=> c == 6'h0B)
        else $error("config");
    a_l0_code: assert property (g == 4 |=> c == 6'h16) else $error("l0");
endmodule
bind ltsr_reporter ltsr_checker ltsr_checker_inst (.*);
`default_nettype wire

/* File: bench/ltsr_user_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ltsr_user_monitor (input wire clock, reset_n, input wire [5:0] code);
    logic [5:0] seen; // Sink only, user logic never stalls it
    always_ff @(posedge clock or negedge reset_n) seen <= !reset_n ? 6'h00 : code;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clock = 0, reset_n = 0, rp = 0;
    logic [3:0] grp = 0;
    logic [2:0] sub = 0;
    wire  [7:0] out;
    int         failures = 0, num_checks = 0;
    ltsr_reporter ltsr_reporter_inst (.clock(clock), .reset_n(reset_n), .state_group(grp),
        .state_sub(sub), .root_port_mode(rp), .neg_width(sub[1:0]), .rx_power_state(sub[1:0]),
        .link_training_state_code(out[7:2]), .rx_power_state_code(out[1:0]));
    ltsr_user_monitor ltsr_user_monitor_inst (.clock(clock), .reset_n(reset_n), .code(out[7:2]));
    initial forever #12.5 clock = ~clock;
    initial begin
        repeat (20) @(posedge clock);
        #2.5 reset_n = 1;
        t_all;
    end
    initial #5000 end_of_test(1);
    task chk(input logic [7:0] got, exp);
        num_checks++;
        failures += int'(got !== exp);
        if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask
    task sweep(int g, r, s, n, b);
        for (int i = 0; i < n; i++) begin
            {grp, rp, sub} = {4'(g), 1'(r), 3'(s + i)};
            #25;
            chk(out, {6'(b + i), 2'(s + i)});
        end
    endtask
    task t_all;
        sweep(0, 0, 1, 1, 6'h02);
        sweep(1, 0, 0, 7, 6'h04);
        sweep(2, 0, 0, 6, 6'h0B);
        sweep(2, 0, 6, 1, 6'h15);
        sweep(3, 0, 0, 4, 6'h11);
        sweep(4, 0, 0, 1, 6'h16);
        sweep(5, 0, 0, 5, 6'h17);
        sweep(6, 0, 0, 5, 6'h1C);
        sweep(7, 0, 0, 1, 6'h21);
        sweep(8, 0, 0, 4, 6'h22);
        sweep(2, 1, 0, 7, 6'h26);
        sweep(9, 0, 0, 1, 6'h2D);
        sweep(10, 0, 0, 6, 6'h2E);
        sweep(2, 0, 7, 1, 6'h10);
        sweep(2, 1, 7, 1, 6'h2C);
        sweep(5, 0, 5, 1, 6'h1B);
        sweep(6, 0, 7, 1, 6'h20);
        sweep(8, 0, 5, 1, 6'h25);
        sweep(10, 0, 7, 1, 6'h33);
        sweep(11, 0, 0, 1, 6'h00);
        sweep(15, 0, 3, 1, 6'h00);
        sweep(0, 0, 2, 1, 6'h00);
        t_reset;
        end_of_test(0);
    endtask
    task t_reset;
        {grp, rp, sub} = {4'h4, 1'b0, 3'h1};
        reset_n = 0;
        #24;
        chk(out, 8'h00);
        #1;
        reset_n = 1;
        #25;
        chk(out, {6'h16, 2'h1});
    endtask
    task end_of_test(int hang);
        failures += hang;
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
endmodule
`default_nettype wire
